// File: hw/uim_top.sv
`timescale 1ns/1ps
`include "uim_defs.svh"
module uim_top
  import uim_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // Peripheral register port
  input  wire logic          per_wr,
  input  wire logic          per_rd,
  input  wire logic [7:0]    per_addr,
  input  wire logic [31:0]   per_wdata,
  output logic      [31:0]   per_rdata_q,
  output logic               per_rvalid_q,
  // Transceiver receive stream
  input  wire uim_pkg::uim_rx_t utmi_rx,
  // Asynchronous transceiver levels
  input  wire logic [1:0]    utmi_linestate,
  input  wire logic [5:0]    utmi_otg_status,
  input  wire logic [2:0]    utmi_serial_rx,
  // Transceiver drive
  output uim_pkg::uim_fc_t   fc_q,
  output uim_pkg::uim_otg_t  otg_q,
  output uim_pkg::uim_ser_t  ser_q,
  // Processor port outputs
  output logic [3:0]         port_q
);
  import uim_pkg::*;

  // ---------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------
  wire wr_rst  = per_wr & (per_addr == `UIM_A_RST);   // Soft reset
  wire wr_ctrl = per_wr & (per_addr == `UIM_A_CTRL);
  wire wr_addr = per_wr & (per_addr == `UIM_A_ADDR);
  wire wr_fc   = per_wr & (per_addr == `UIM_A_FC);
  wire wr_otgc = per_wr & (per_addr == `UIM_A_OTGC);
  wire wr_ser  = per_wr & (per_addr == `UIM_A_SER);
  wire wr_flg  = per_wr & (per_addr == `UIM_A_FLG);
  wire wr_stk  = per_wr & (per_addr == `UIM_A_STK);
  wire wr_msk  = per_wr & (per_addr == `UIM_A_MSK);
  wire wr_sof  = per_wr & (per_addr == `UIM_A_SOF);
  wire wr_epm  = per_wr & (per_addr == `UIM_A_EPM);
  wire wr_otgm = per_wr & (per_addr == `UIM_A_OTGM);
  wire wr_pwr  = per_wr & (per_addr == `UIM_A_PWR);
  wire wr_phyc = per_wr & (per_addr == `UIM_A_PHYC);
  wire soft_rst = wr_rst;                 // Any data clears state

  // ---------------------------------------------------------------
  // Manager state
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;       // Mode enables
  logic [6:0]  dev_addr_q;   // Device address filter
  logic [6:0]  flg_q;        // Signal flag vector
  logic [6:0]  stk_q;        // Flag stickiness select
  logic [31:0] msk_q;        // Four port masks
  logic [10:0] sof_q;        // Frame number
  logic [3:0]  pid_q;        // Last packet identifier
  logic [4:0]  ep_q;         // Valid bit and endpoint
  logic [15:0] epm_q;        // Endpoint match bits
  logic [31:0] otgm_q;       // OTG flag mask
  logic [8:0]  pwr_q;        // Power signalling data
  logic [31:0] phyc_q;       // Transceiver control store

  wire proc_en = ctrl_q[`UIM_C_PROC];
  wire chk_en  = ctrl_q[`UIM_C_CHK];
  wire lsd_en  = ctrl_q[`UIM_C_LSD];
  wire soft_en = ctrl_q[`UIM_C_SOFT];

  // ---------------------------------------------------------------
  // Pin synchronisers for levels from outside the clock
  // ---------------------------------------------------------------
  // Three stages; a change is taken once stages two and three agree,
  // so a single-cycle glitch in stage two never reaches the logic.
  logic [10:0] s1_q, s2_q, s3_q, pin_q;
  wire  [10:0] pin_raw = {utmi_serial_rx, utmi_otg_status, utmi_linestate};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 11'h000;
      s2_q  <= 11'h000;
      s3_q  <= 11'h000;
      pin_q <= 11'h000;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        pin_q <= s3_q;
      end
    end
  end
  wire [1:0] ls_s   = pin_q[1:0];
  wire [5:0] otgf_s = pin_q[7:2];
  wire [2:0] serr_s = pin_q[10:8];

  // ---------------------------------------------------------------
  // Check functions
  // ---------------------------------------------------------------
  // Serial order is least significant bit first, so both checks use
  // the reflected polynomial on a right-shifting register.
  function automatic logic [4:0] crc5_f(input logic [10:0] d);
    logic [4:0] c;
    logic       fb;
    c = `UIM_CRC5_I;
    for (int i = 0; i < 11; i++) begin
      fb = c[0] ^ d[i];
      c  = (c >> 1) ^ (fb ? `UIM_CRC5_P : 5'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] crc16_f(input logic [15:0] ci,
                                          input logic [7:0]  d);
    logic [15:0] c;
    logic        fb;
    c = ci;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c  = (c >> 1) ^ (fb ? `UIM_CRC16_P : 16'h0000);
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Packet tracking
  // ---------------------------------------------------------------
  logic        rxa_q;        // Receive active, last cycle
  logic [1:0]  cnt_q;        // Bytes seen, saturates at three
  logic [7:0]  pidb_q;       // First byte of packet
  logic [15:0] tok_q;        // Token body bytes
  logic [15:0] crc16_q;      // Running data check

  wire pkt_start = utmi_rx.active & ~rxa_q;
  wire pkt_end   = ~utmi_rx.active & rxa_q;
  wire byte_in   = utmi_rx.active & utmi_rx.valid;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxa_q   <= 1'b0;
      cnt_q   <= 2'h0;
      pidb_q  <= 8'h00;
      tok_q   <= 16'h0000;
      crc16_q <= `UIM_CRC16_I;
    end else if (soft_rst) begin
      rxa_q   <= 1'b0;
      cnt_q   <= 2'h0;
      pidb_q  <= 8'h00;
      tok_q   <= 16'h0000;
      crc16_q <= `UIM_CRC16_I;
    end else begin
      rxa_q <= utmi_rx.active;
      if (pkt_start) begin
        cnt_q   <= 2'h0;
        crc16_q <= `UIM_CRC16_I;
      end
      if (byte_in) begin
        // Identifier byte first, then body
        if (cnt_q == 2'h0) begin
          pidb_q <= utmi_rx.data;
        end else begin
          crc16_q <= crc16_f(crc16_q, utmi_rx.data);
        end
        if (cnt_q == 2'h1) tok_q[7:0] <= utmi_rx.data;
        if (cnt_q == 2'h2) tok_q[15:8] <= utmi_rx.data;
        if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Packet evaluation at end of receive
  // ---------------------------------------------------------------
  wire [3:0]  pid_n   = pidb_q[3:0];
  wire        pid_ok  = (pidb_q[7:4] == ~pidb_q[3:0]);
  wire        is_tok  = (pid_n[1:0] == 2'h1);        // OUT IN SOF SETUP
  wire        is_sof  = (pid_n == `UIM_PID_SOF);
  wire        is_dat  = (pid_n[1:0] == 2'h3);        // DATA0/1/2, MDATA
  wire        crc5_ok = (crc5_f(tok_q[10:0]) == ~tok_q[15:11]);
  wire        chk_ok  = ~chk_en | (pid_ok & crc5_ok);
  wire        tok_rdy = pkt_end & proc_en & is_tok
                        & (cnt_q == 2'h3) & chk_ok;
  wire        adr_hit = (tok_q[6:0] == dev_addr_q);
  wire        tok_acc = tok_rdy & ~is_sof & adr_hit;
  wire        sof_acc = tok_rdy & is_sof;
  wire        crc_bad = pkt_end & proc_en & is_dat
                        & (crc16_q != `UIM_CRC16_R);

  // ---------------------------------------------------------------
  // Flag events
  // ---------------------------------------------------------------
  wire  [6:0] ev;
  wire  [6:0] clr_v = wr_flg ? per_wdata[6:0] : 7'h00;
  assign ev[`UIM_F_TOK] = tok_acc | (sof_acc & soft_en);
  assign ev[`UIM_F_SE0] = lsd_en & (ls_s == `UIM_LS_SE0);
  assign ev[`UIM_F_K]   = lsd_en & (ls_s == `UIM_LS_K);
  assign ev[`UIM_F_J]   = lsd_en & (ls_s == `UIM_LS_J);
  assign ev[`UIM_F_CRC] = crc_bad;
  assign ev[`UIM_F_RXA] = utmi_rx.active;
  assign ev[`UIM_F_RXE] = utmi_rx.error;

  // ---------------------------------------------------------------
  // Per-flag update, one slice per bit
  // ---------------------------------------------------------------
  // Set wins over a software clear in the same cycle, so no event is
  // lost. The two level flags copy their input unless sticky.
  for (genvar i = 0; i < 7; i++) begin : g_flag
    logic nxt;
    wire  keep = (pkt_start | clr_v[i]) ? 1'b0 : flg_q[i];
    always_comb begin
      if (stk_q[i]) begin
        nxt = (flg_q[i] & ~clr_v[i]) | ev[i];
      end else if (i <= `UIM_F_RXA) begin
        nxt = ev[i];
      end else begin
        nxt = keep | ev[i];
      end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        flg_q[i] <= 1'b0;
      end else if (soft_rst) begin
        flg_q[i] <= 1'b0;
      end else begin
        flg_q[i] <= nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Port outputs: OR of masked flags
  // ---------------------------------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_port
    wire hit = |(flg_q & msk_q[k*8 +: 7]);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        port_q[k] <= 1'b0;
      end else begin
        port_q[k] <= hit;
      end
    end
  end

  // ---------------------------------------------------------------
  // Manager configuration and capture registers
  // ---------------------------------------------------------------
  // Cleared by a soft reset; the transceiver drive is not.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= 8'h00;
      dev_addr_q <= 7'h00;
      stk_q      <= 7'h00;
      msk_q      <= 32'h0000_0000;
      sof_q      <= 11'h000;
      pid_q      <= 4'h0;
      ep_q       <= 5'h00;
      epm_q      <= 16'h0000;
      otgm_q     <= 32'h0000_0000;
      pwr_q      <= 9'h000;
      phyc_q     <= 32'h0000_0000;
    end else if (soft_rst) begin
      ctrl_q     <= 8'h00;
      dev_addr_q <= 7'h00;
      stk_q      <= 7'h00;
      msk_q      <= 32'h0000_0000;
      sof_q      <= 11'h000;
      pid_q      <= 4'h0;
      ep_q       <= 5'h00;
      epm_q      <= 16'h0000;
      otgm_q     <= 32'h0000_0000;
      pwr_q      <= 9'h000;
      phyc_q     <= 32'h0000_0000;
    end else begin
      // Reserved bit 3 never stores
      if (wr_ctrl) ctrl_q <= per_wdata[7:0] & 8'hF7;
      if (wr_addr) dev_addr_q <= per_wdata[6:0];
      if (wr_stk)  stk_q <= per_wdata[6:0];
      if (wr_msk)  msk_q <= per_wdata;
      if (wr_epm)  epm_q <= per_wdata[15:0];
      if (wr_otgm) otgm_q <= per_wdata;
      if (wr_pwr)  pwr_q <= per_wdata[8:0];
      if (wr_phyc) phyc_q <= per_wdata & `UIM_PHYC_WM;
      // Received frame number overrides a same-cycle write
      if (sof_acc) sof_q <= tok_q[10:0];
      else if (wr_sof) sof_q <= per_wdata[10:0];
      if (byte_in && cnt_q == 2'h0) pid_q <= utmi_rx.data[3:0];
      if (tok_acc) ep_q <= {1'b1, tok_q[10:7]};
    end
  end

  // ---------------------------------------------------------------
  // Transceiver drive registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_q  <= `UIM_FC_RST;
      otg_q <= 8'h00;
      ser_q <= `UIM_SER_RST;
    end else begin
      if (wr_fc)   fc_q  <= per_wdata[4:0];
      if (wr_otgc) otg_q <= per_wdata[7:0] & 8'hDF;
      if (wr_ser)  ser_q <= per_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Read selection
  // ---------------------------------------------------------------
  // Full words only; unmapped offsets read zero.
  wire [31:0] rd_mux =
      ({32{per_addr == `UIM_A_CTRL}} & {24'h0, ctrl_q})
    | ({32{per_addr == `UIM_A_ADDR}} & {25'h0, dev_addr_q})
    | ({32{per_addr == `UIM_A_FC}}   & {27'h0, fc_q})
    | ({32{per_addr == `UIM_A_OTGC}} & {24'h0, otg_q})
    | ({32{per_addr == `UIM_A_OTGF}} & {26'h0, otgf_s})
    | ({32{per_addr == `UIM_A_SER}}  & {25'h0, serr_s, ser_q})
    | ({32{per_addr == `UIM_A_FLG}}  & {25'h0, flg_q})
    | ({32{per_addr == `UIM_A_STK}}  & {25'h0, stk_q})
    | ({32{per_addr == `UIM_A_MSK}}  & msk_q)
    | ({32{per_addr == `UIM_A_SOF}}  & {21'h0, sof_q})
    | ({32{per_addr == `UIM_A_PID}}  & {28'h0, pid_q})
    | ({32{per_addr == `UIM_A_EP}}   & {27'h0, ep_q})
    | ({32{per_addr == `UIM_A_EPM}}  & {16'h0, epm_q})
    | ({32{per_addr == `UIM_A_OTGM}} & otgm_q)
    | ({32{per_addr == `UIM_A_PWR}}  & {23'h0, pwr_q})
    | ({32{per_addr == `UIM_A_PHYC}} & phyc_q);

  // Read answer one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_rdata_q  <= 32'h0000_0000;
      per_rvalid_q <= 1'b0;
    end else begin
      per_rvalid_q <= per_rd;
      if (per_rd) per_rdata_q <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  soft_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_rst |=> (ctrl_q == 8'h00 && flg_q == 7'h00
                && ep_q == 5'h00 && fc_q == $past(fc_q)))
    else $error("soft reset left state");
  token_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(flg_q[`UIM_F_TOK]) |-> $past(proc_en))
    else $error("token flag without processing");
  addr_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_addr && !wr_rst) |=> dev_addr_q == $past(per_wdata[6:0]))
    else $error("device address not stored");
  fc_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_fc |=> fc_q == $past(per_wdata[4:0]))
    else $error("function control not driven");
  otg_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (per_rd && per_addr == `UIM_A_OTGF)
      |=> per_rvalid_q && per_rdata_q == {26'h0, $past(otgf_s)})
    else $error("otg flags not mirrored");
  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !soft_rst |=> ($past(flg_q & stk_q & ~clr_v) & ~flg_q) == 7'h00)
    else $error("sticky flag dropped");
  port_or_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> port_q[0] == $past(|(flg_q & msk_q[6:0])))
    else $error("port output not masked or");
  rxa_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!stk_q[`UIM_F_RXA] && !soft_rst)
      |=> flg_q[`UIM_F_RXA] == $past(utmi_rx.active))
    else $error("rx active flag not following");
  pkt_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pkt_start && !stk_q[`UIM_F_CRC] && !crc_bad)
      |=> !flg_q[`UIM_F_CRC])
    else $error("non-sticky flag not cleared");
endmodule

// File: inc/uim_defs.svh
`ifndef UIM_DEFS_SVH
`define UIM_DEFS_SVH
// ---------------------------------------------------------------
// Register offsets (byte addresses of 32-bit words)
// ---------------------------------------------------------------
`define UIM_A_RST   8'h00
`define UIM_A_CTRL  8'h04
`define UIM_A_ADDR  8'h08
`define UIM_A_FC    8'h0C
`define UIM_A_OTGC  8'h10
`define UIM_A_OTGF  8'h14
`define UIM_A_SER   8'h18
`define UIM_A_FLG   8'h1C
`define UIM_A_STK   8'h20
`define UIM_A_MSK   8'h24
`define UIM_A_SOF   8'h28
`define UIM_A_PID   8'h2C
`define UIM_A_EP    8'h30
`define UIM_A_EPM   8'h34
`define UIM_A_OTGM  8'h38
`define UIM_A_PWR   8'h3C
`define UIM_A_PHYC  8'h40
// ---------------------------------------------------------------
// Control bit positions and reset values
// ---------------------------------------------------------------
`define UIM_C_PROC  0
`define UIM_C_CHK   1
`define UIM_C_LSD   2
`define UIM_C_SOFT  6
`define UIM_FC_RST  5'h07
`define UIM_SER_RST 4'h2
`define UIM_PHYC_WM 32'h0004_3FF0
// ---------------------------------------------------------------
// Flag bit positions
// ---------------------------------------------------------------
`define UIM_F_TOK   6
`define UIM_F_SE0   5
`define UIM_F_K     4
`define UIM_F_J     3
`define UIM_F_CRC   2
`define UIM_F_RXA   1
`define UIM_F_RXE   0
// ---------------------------------------------------------------
// Packet codes and check constants
// ---------------------------------------------------------------
`define UIM_LS_SE0  2'h0
`define UIM_LS_J    2'h1
`define UIM_LS_K    2'h2
`define UIM_PID_SOF 4'h5
`define UIM_CRC5_I  5'h1F
`define UIM_CRC5_P  5'h14
`define UIM_CRC16_I 16'hFFFF
`define UIM_CRC16_P 16'hA001
`define UIM_CRC16_R 16'hB001
`endif

// File: inc/uim_pkg.sv
package uim_pkg;
  // Bytes arriving from the transceiver
  typedef struct packed {
    logic       active;
    logic       valid;
    logic       error;
    logic [7:0] data;
  } uim_rx_t;
  // Transceiver function select
  typedef struct packed {
    logic [2:0] opmode;
    logic       termsel;
    logic       xcvrsel;
  } uim_fc_t;
  // Serial-mode drive
  typedef struct packed {
    logic se0;
    logic dat;
    logic txen_n;
    logic fsls;
  } uim_ser_t;
  // On-the-go drive
  typedef struct packed {
    logic ext_vbus_ind;
    logic ext_vbus_drv;
    logic unused5;
    logic chrg_vbus;
    logic dischrg_vbus;
    logic dm_pulldown;
    logic dp_pulldown;
    logic id_pin_pullup;
  } uim_otg_t;
endpackage

// File: bench/uim_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host seen through the transceiver: packet bytes and line levels
// ---------------------------------------------------------------
module uim_host_model
  import uim_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Receive stream and slow levels
  output uim_pkg::uim_rx_t rx,
  output logic [1:0]       ls,
  output logic [5:0]       otg,
  output logic [2:0]       srx
);
  import uim_pkg::*;
  // Idle bus, line parked at J
  initial begin
    rx = '0;
    ls = 2'h1;
    otg = 6'h00;
    srx = 3'h0;
  end
  // One byte per cycle; data is scrambled once no longer valid
  task automatic pkt(input logic [7:0] b [$]);
    @(negedge sys_clk);
    rx.active = 1'b1;
    foreach (b[i]) begin
      @(negedge sys_clk);
      rx.valid = 1'b1;
      rx.data = b[i];
    end
    @(negedge sys_clk);
    rx.active = 1'b0;
    rx.valid = 1'b0;
    rx.data = ~rx.data;
    repeat (4) @(negedge sys_clk);
  endtask
  // Token with CRC5 over eleven bits sent LSB first; bad flips one bit
  task automatic tok(input logic [3:0] pid, input logic [10:0] f,
                     input logic bad);
    logic [4:0] c;
    logic [7:0] q [$];
    c = 5'h1F;
    for (int i = 0; i < 11; i++) begin
      c = (c >> 1) ^ (((c[0] ^ f[i]) == 1'b1) ? 5'h14 : 5'h00);
    end
    c = ~c ^ {4'h0, bad};
    q = '{{~pid, pid}, f[7:0], {c, f[10:8]}};
    pkt(q);
  endtask
  // Data packet whose trailing check bytes are wrong
  task automatic dat();
    logic [7:0] q [$];
    q = '{8'hC3, 8'h00, 8'h12, 8'h34};
    pkt(q);
  endtask
  // Slow levels, changed off the sampling edge
  task automatic lines(input logic [1:0] l, input logic [5:0] o,
                       input logic [2:0] s);
    @(negedge sys_clk);
    ls = l;
    otg = o;
    srx = s;
  endtask
  // Receive error level, changed off the sampling edge
  task automatic err(input logic e);
    @(negedge sys_clk);
    rx.error = e;
  endtask
endmodule

// File: bench/usb_phy_interface_manager_tb.sv
`timescale 1ns/1ps
`include "uim_defs.svh"
module usb_phy_interface_manager_tb;
  import uim_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        sys_clk, rst_n, per_wr, per_rd, per_rvalid_q;
  logic [7:0]  per_addr;
  logic [31:0] per_wdata, per_rdata_q, rv;
  uim_rx_t     utmi_rx;
  logic [1:0]  ls;
  logic [5:0]  otg;
  logic [2:0]  srx;
  uim_fc_t     fc_q;
  uim_otg_t    otg_q;
  uim_ser_t    ser_q;
  logic [3:0]  port_q;
  int          bad_count, checked, cyc;
  uim_top uim_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .per_wr(per_wr), .per_rd(per_rd), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata_q(per_rdata_q),
    .per_rvalid_q(per_rvalid_q), .utmi_rx(utmi_rx),
    .utmi_linestate(ls), .utmi_otg_status(otg), .utmi_serial_rx(srx),
    .fc_q(fc_q), .otg_q(otg_q), .ser_q(ser_q), .port_q(port_q));
  uim_host_model uim_host_model_inst (.sys_clk(sys_clk), .rx(utmi_rx),
    .ls(ls), .otg(otg), .srx(srx));
  // ---------------------------------------------------------------
  // Clock, hang guard and helpers
  // ---------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;
  // Whole run is a few hundred cycles; far above that means a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Whole-word write, strobe held over one rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    per_wr = 1'b1;
    per_addr = a;
    per_wdata = d;
    @(negedge sys_clk);
    per_wr = 1'b0;
  endtask
  // Whole-word read; answer stands for the one cycle after the edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    per_rd = 1'b1;
    per_addr = a;
    @(negedge sys_clk);
    per_rd = 1'b0;
    chk("rvalid", {31'h0, per_rvalid_q}, 32'h1);
    d = per_rdata_q;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    per_wr = 1'b0;
    per_rd = 1'b0;
    per_addr = 8'h00;
    per_wdata = 32'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    // Reset values of registers and drive
    rc(`UIM_A_CTRL, 32'h0);
    rc(`UIM_A_ADDR, 32'h0);
    rc(`UIM_A_FC, 32'h07);
    rc(`UIM_A_SER, 32'h02);
    rc(`UIM_A_PID, 32'h0);
    chk("otg_q", {24'h0, otg_q}, 32'h0);
    // Software sets the address only after enumeration
    wr(`UIM_A_ADDR, 32'h05);
    wr(`UIM_A_CTRL, 32'h03);
    wr(`UIM_A_MSK, 32'h0000_4000);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h05}, 1'b0);
    rc(`UIM_A_FLG, 32'h40);
    chk("port", {28'h0, port_q}, 32'h2);
    rc(`UIM_A_EP, 32'h19);
    rc(`UIM_A_PID, 32'h1);
    // Foreign address, then bad check: flag cleared and not set again
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h06}, 1'b0);
    rc(`UIM_A_FLG, 32'h0);
    chk("port", {28'h0, port_q}, 32'h0);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h05}, 1'b1);
    rc(`UIM_A_FLG, 32'h0);
    // Checking off lets a bad token through; processing off stops all
    wr(`UIM_A_CTRL, 32'h01);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h05}, 1'b1);
    rc(`UIM_A_FLG, 32'h40);
    wr(`UIM_A_CTRL, 32'h00);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h05}, 1'b0);
    rc(`UIM_A_FLG, 32'h0);
    // Sticky token flag survives a packet until written with one
    wr(`UIM_A_CTRL, 32'h03);
    wr(`UIM_A_STK, 32'h40);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h05}, 1'b0);
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h06}, 1'b0);
    rc(`UIM_A_FLG, 32'h40);
    wr(`UIM_A_FLG, 32'h40);
    rc(`UIM_A_FLG, 32'h0);
    // Frame number from a start-of-frame packet, then software write
    uim_host_model_inst.tok(4'h5, 11'h3AB, 1'b0);
    rc(`UIM_A_SOF, 32'h3AB);
    // Frame start counts as a token only in its own mode
    wr(`UIM_A_CTRL, 32'h43);
    uim_host_model_inst.tok(4'h5, 11'h3AB, 1'b0);
    rc(`UIM_A_FLG, 32'h40);
    wr(`UIM_A_FLG, 32'h40);
    wr(`UIM_A_SOF, 32'h123);
    rc(`UIM_A_SOF, 32'h123);
    uim_host_model_inst.dat();
    rc(`UIM_A_FLG, 32'h04);
    // The next packet clears the non-sticky check flag
    uim_host_model_inst.tok(4'h1, {4'h9, 7'h06}, 1'b0);
    rc(`UIM_A_FLG, 32'h0);
    // Levels settle before the decoder runs, so no stale J is caught
    uim_host_model_inst.lines(2'h2, 6'h2A, 3'h5);
    repeat (8) @(negedge sys_clk);
    wr(`UIM_A_CTRL, 32'h07);
    rd(`UIM_A_FLG, rv);
    chk("line flags", rv & 32'h38, 32'h10);
    rc(`UIM_A_OTGF, 32'h2A);
    uim_host_model_inst.err(1'b1);
    rd(`UIM_A_FLG, rv);
    chk("rx error flag", rv & 32'h01, 32'h01);
    uim_host_model_inst.err(1'b0);
    // Transceiver drive fields
    wr(`UIM_A_FC, 32'h15);
    chk("fc_q", {27'h0, fc_q}, 32'h15);
    wr(`UIM_A_OTGC, 32'hFF);
    chk("otg_q", {24'h0, otg_q}, 32'hDF);
    wr(`UIM_A_SER, 32'hFD);
    chk("ser_q", {28'h0, ser_q}, 32'hD);
    rc(`UIM_A_SER, 32'h5D);
    wr(`UIM_A_CTRL, 32'hFF);
    rc(`UIM_A_CTRL, 32'hF7);
    // Soft reset keeps the transceiver drive; unmapped place reads zero
    wr(`UIM_A_RST, 32'h1234_5678);
    rc(`UIM_A_CTRL, 32'h0);
    rc(`UIM_A_ADDR, 32'h0);
    rc(`UIM_A_SOF, 32'h0);
    chk("fc_q", {27'h0, fc_q}, 32'h15);
    wr(8'h44, 32'hFFFF_FFFF);
    rc(8'h44, 32'h0);
    end_of_test();
  end
endmodule
